/* core/ltp_ahb_slave.sv */
module ltp_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [11:0] haddr,
  input wire logic [2:0] hsize,
  output logic wr_pend,
  output logic rd_pend,
  output logic [11:0] addr_q
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend <= hsel && htrans == ltp_pkg::LTP_HTRANS_NONSEQ && hwrite
        && hsize == ltp_pkg::LTP_HSIZE_WORD;
      rd_pend <= hsel && htrans == ltp_pkg::LTP_HTRANS_NONSEQ && !hwrite;
      addr_q <= haddr;
    end
  end
endmodule

/* core/ltp_area_sel.sv */
module ltp_area_sel (
  input wire logic [3:0] nibble,
  input wire logic [7:0] boundary,
  output ltp_pkg::ltp_area_t area
);
  always_comb begin
    if (nibble >= boundary[ltp_pkg::LTP_UPPER_MSB:ltp_pkg::LTP_UPPER_LSB]) begin
      area = ltp_pkg::LTP_AREA_UPPER;
    end else if (nibble >= boundary[ltp_pkg::LTP_BANK_MSB:ltp_pkg::LTP_BANK_LSB]) begin
      area = ltp_pkg::LTP_AREA_BANK;
    end else begin
      area = ltp_pkg::LTP_AREA_LOWER;
    end
  end
endmodule

/* core/ltp_mmu.sv */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
module ltp_mmu (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ltp_pkg::ltp_req_t req,
  output logic [19:0] paddr,
  output ltp_pkg::ltp_area_t area
);
  ltp_pkg::ltp_map_t map;
  ltp_pkg::ltp_area_t sel_area;
  logic wr_pend;
  logic rd_pend;
  logic [11:0] addr_q;
  logic [7:0] base;

  ////////////////////////////////////////////////////////////////////////
  ltp_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .haddr(haddr[11:0]),
    .hsize(hsize),
    .wr_pend(wr_pend),
    .rd_pend(rd_pend),
    .addr_q(addr_q)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // translation registers; write in data phase, live the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      map.boundary <= ltp_pkg::LTP_RST_BOUNDARY;
      map.upper_base <= ltp_pkg::LTP_RST_BASE;
      map.bank_base <= ltp_pkg::LTP_RST_BASE;
    end else if (wr_pend) begin
      case (addr_q)
        ltp_pkg::LTP_OFS_BOUNDARY: map.boundary <= hwdata[7:0];
        ltp_pkg::LTP_OFS_UPPER_BASE: map.upper_base <= hwdata[7:0];
        ltp_pkg::LTP_OFS_BANK_BASE: map.bank_base <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data registered at address phase so it stands during data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel && htrans == ltp_pkg::LTP_HTRANS_NONSEQ && !hwrite) begin
      case (haddr[11:0])
        ltp_pkg::LTP_OFS_BOUNDARY: hrdata <= {24'h000000, map.boundary};
        ltp_pkg::LTP_OFS_UPPER_BASE: hrdata <= {24'h000000, map.upper_base};
        ltp_pkg::LTP_OFS_BANK_BASE: hrdata <= {24'h000000, map.bank_base};
        ltp_pkg::LTP_OFS_STATUS: hrdata <= {28'h0000000, 2'h0, sel_area};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ltp_area_sel u_sel (
    .nibble(req.laddr[15:12]),
    .boundary(map.boundary),
    .area(sel_area)
  );

  always_comb begin
    case (sel_area)
      ltp_pkg::LTP_AREA_UPPER: base = map.upper_base;
      ltp_pkg::LTP_AREA_BANK: base = map.bank_base;
      default: base = 8'h00;
    endcase
  end

  // combinational path: no added cycle
  always_comb begin
    area = sel_area;
    case (req.kind)
      ltp_pkg::LTP_CYC_IO: paddr = {4'h0, req.laddr};
      ltp_pkg::LTP_CYC_DMA: paddr = req.dma_addr;
      ltp_pkg::LTP_CYC_MEM: paddr = {base + {4'h0, req.laddr[15:12]},
        req.laddr[11:0]};
      default: paddr = {base + {4'h0, req.laddr[15:12]}, req.laddr[11:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  a_io_high_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_IO |-> paddr == {4'h0, req.laddr})
    else $error("io address not passed");
  a_dma_direct: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_DMA |-> paddr == req.dma_addr)
    else $error("dma address not direct");
  a_low_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_MEM |-> paddr[11:0] == req.laddr[11:0])
    else $error("page offset altered");
  a_lower_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_MEM && req.laddr[15:12] < map.boundary[3:0]
    |-> paddr[19:12] == {4'h0, req.laddr[15:12]})
    else $error("lower area relocated");
  a_upper_base: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_MEM && req.laddr[15:12] >= map.boundary[7:4]
    |-> paddr[19:12] == map.upper_base + {4'h0, req.laddr[15:12]})
    else $error("upper area base wrong");
  a_bank_base: assert property (@(posedge hclk) disable iff (!hresetn)
    req.kind == ltp_pkg::LTP_CYC_MEM && req.laddr[15:12] < map.boundary[7:4]
    && req.laddr[15:12] >= map.boundary[3:0]
    |-> paddr[19:12] == map.bank_base + {4'h0, req.laddr[15:12]})
    else $error("bank area base wrong");
  a_write_next: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && addr_q == ltp_pkg::LTP_OFS_BOUNDARY
    |=> map.boundary == $past(hwdata[7:0]))
    else $error("boundary write lost");
  a_hold_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_pend |=> $stable(map))
    else $error("map changed without write");
  c_io: cover property (@(posedge hclk) req.kind == ltp_pkg::LTP_CYC_IO);
  c_dma: cover property (@(posedge hclk) req.kind == ltp_pkg::LTP_CYC_DMA);
  c_bank: cover property (@(posedge hclk) sel_area == ltp_pkg::LTP_AREA_BANK);
  c_read: cover property (@(posedge hclk) rd_pend);
endmodule

/* core/ltp_pkg.sv */
// Functional notes
// - map every 16-bit logical memory address to a 20-bit physical address
// - translation is combinational, no extra sequential step in a cycle
// - logical space splits into lower common, bank and upper common regions
// - region boundaries are programmable at 4KB granularity only
// - lower common region always maps at physical base zero
// - bank and upper common relocate freely on 4KB, overlap allowed
// - all memory cycle kinds are translated
// - I/O cycles pass the 16-bit logical address unchanged
// - I/O cycles drive physical address bits 19..16 to zero
// - DMA ownership drives the DMA 20-bit address straight out
// - upper-common start field gives first upper common address
// - bank start field gives first bank address
// - base registers relocate regions within 1024KB at 4KB resolution
// - physical address is base plus top logical nibble, low 12 bits kept
// - boundary register: upper-common start bits 7..4, bank start bits 3..0
// - reset sets upper-common start to all ones, clears the rest
// - a written value takes effect from the next cycle; the code acts only on word-size writes (hsize word) and ignores others
package ltp_pkg;
  localparam logic [11:0] LTP_OFS_UPPER_BASE = 12'h0E0;
  localparam logic [11:0] LTP_OFS_BANK_BASE = 12'h0E4;
  localparam logic [11:0] LTP_OFS_BOUNDARY = 12'h0E8;
  localparam logic [11:0] LTP_OFS_STATUS = 12'h0EC;
  localparam int LTP_UPPER_MSB = 7;
  localparam int LTP_UPPER_LSB = 4;
  localparam int LTP_BANK_MSB = 3;
  localparam int LTP_BANK_LSB = 0;
  localparam int LTP_PAGE_BITS = 12;
  localparam logic [7:0] LTP_RST_BOUNDARY = 8'hF0;
  localparam logic [7:0] LTP_RST_BASE = 8'h00;
  localparam logic [1:0] LTP_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] LTP_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {LTP_CYC_MEM, LTP_CYC_IO, LTP_CYC_DMA} ltp_cycle_t;
  typedef enum logic [1:0] {LTP_AREA_LOWER, LTP_AREA_BANK, LTP_AREA_UPPER} ltp_area_t;

  typedef struct packed {
    logic [7:0] boundary;
    logic [7:0] upper_base;
    logic [7:0] bank_base;
  } ltp_map_t;

  typedef struct packed {
    ltp_cycle_t kind;
    logic [15:0] laddr;
    logic [19:0] dma_addr;
  } ltp_req_t;
endpackage

/* tb/ltp_cpu_model.sv */
module ltp_cpu_model (
  input wire logic hclk,
  output ltp_pkg::ltp_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // a new cycle request starts just after a rising edge and stands until the next one
  task automatic issue(input ltp_pkg::ltp_cycle_t k, input logic [15:0] la,
      input logic [19:0] da);
    @(posedge hclk);
    req <= '{kind: k, laddr: la, dma_addr: da};
  endtask
endmodule

/* tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = ltp_pkg::LTP_HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp;
  ltp_pkg::ltp_req_t req;
  logic [19:0] paddr;
  ltp_pkg::ltp_area_t area;
  logic [7:0] bnd = 8'hF0, ub = 8'h00, bb = 8'h00;
  logic [23:0] cfg_tab [4] = '{24'h84F830, 24'h443C05, 24'h401122, 24'hFFA00F};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  initial forever #10 hclk = ~hclk;
  ltp_cpu_model cpu (.hclk(hclk), .req(req));
  ltp_mmu dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req(req), .paddr(paddr), .area(area));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= ltp_pkg::LTP_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    chk(hresp, 32'h0);
  endtask
  task automatic rdall();
    xfer(1'b0, ltp_pkg::LTP_OFS_BOUNDARY, 32'h0, rd);
    chk(rd, {24'h0, bnd});
    xfer(1'b0, ltp_pkg::LTP_OFS_UPPER_BASE, 32'h0, rd);
    chk(rd, {24'h0, ub});
    xfer(1'b0, ltp_pkg::LTP_OFS_BANK_BASE, 32'h0, rd);
    chk(rd, {24'h0, bb});
  endtask
  task automatic wrall(input logic [23:0] c);
    {bnd, ub, bb} = c;
    xfer(1'b1, ltp_pkg::LTP_OFS_BOUNDARY, {24'hA5A5A5, bnd}, rd);
    xfer(1'b1, ltp_pkg::LTP_OFS_UPPER_BASE, {24'hA5A5A5, ub}, rd);
    xfer(1'b1, ltp_pkg::LTP_OFS_BANK_BASE, {24'hA5A5A5, bb}, rd);
  endtask
  // expected area and physical address of a memory cycle from the mirrored registers
  function automatic logic [21:0] xl(input logic [15:0] la);
    if (la[15:12] >= bnd[7:4])
      return {ltp_pkg::LTP_AREA_UPPER, ub + la[15:12], la[11:0]};
    if (la[15:12] >= bnd[3:0])
      return {ltp_pkg::LTP_AREA_BANK, bb + la[15:12], la[11:0]};
    return {ltp_pkg::LTP_AREA_LOWER, 4'h0, la};
  endfunction
  task automatic tr(input ltp_pkg::ltp_cycle_t k, input logic [15:0] la,
      input logic [19:0] da);
    cpu.issue(k, la, da);
    @(negedge hclk);
    if (k == ltp_pkg::LTP_CYC_MEM)
      chk({area, paddr}, xl(la));
    else
      chk(paddr, k == ltp_pkg::LTP_CYC_IO ? {4'h0, la} : da);
  endtask
  task automatic sweep();
    for (int i = 0; i < 16; i++)
      tr(ltp_pkg::LTP_CYC_MEM, {4'(i), 12'hA5C}, 20'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdall();
    sweep();
    for (int i = 0; i < 4; i++) begin
      wrall(cfg_tab[i]);
      rdall();
      sweep();
    end
    tr(ltp_pkg::LTP_CYC_MEM, 16'hF123, 20'h0);
    ub = 8'h12;
    xfer(1'b1, ltp_pkg::LTP_OFS_UPPER_BASE, 32'h12, rd);
    #1;
    chk(paddr, 20'h21123);
    hsize <= 3'h0;
    xfer(1'b1, ltp_pkg::LTP_OFS_BOUNDARY, 32'h0, rd);
    hsize <= ltp_pkg::LTP_HSIZE_WORD;
    rdall();
    xfer(1'b0, 12'h0F0, 32'h0, rd);
    chk(rd, 32'h0);
    tr(ltp_pkg::LTP_CYC_IO, 16'hFFFF, 20'h0);
    tr(ltp_pkg::LTP_CYC_DMA, 16'h1234, 20'hABCDE);
    summarize();
  end
endmodule
